// ==== card_regs_pkg.sv ====
// Notes on behaviour
// - Sixteen-bit interrupt enable mask, one bit per cause; bit 15 active controller.
// - Status low byte: system controller bit 7, active controller bit 6, zero, address.
// - Status bit 8 holds the low bit of the last recognized address.
// - NDAC and NRFD indications are meaningful only while addressed to talk.
// - SRQ indication is meaningful only while active controller.
// - Identity bit 7 reads one when the spare jumper is fitted.
// - Identity bits 6 to 0 return a fixed card type code.
// - Built-in interface reads the identity register as a fixed zero byte.
// - Reading both interrupt status registers or data-line status has a side effect.
// - Interrupt and DMA status bit 7 reads one while card interrupts are enabled.
// - Bit 6 reads one while the card requests service.
// - Bits 5 and 4 encode interrupt level 3 to 6; built-in fixed at 3.
// - Bits 1 and 0 report DMA channel one and zero enabled.
// - Bits 3 and 2 are unused; software must not rely on them.
// - On the built-in interface only the DMA channel zero bit is meaningful.
// - Poll mask: unconfigure bit 4, sense bit 3, response line in bits 2 to 0.
// - Bus line word shows control lines in bits 15 to 8, data lines below.
// - Status high byte flags REM, LLO, ATN, LPAS, TPAS, LADS, TADS at 15 to 9.
package card_regs_pkg;

  localparam logic [4:0] RD_CARD_IDENTITY = 5'h01;
  localparam logic [4:0] RD_INTERRUPT_DMA_STATUS = 5'h03;
  localparam logic [4:0] RD_INTERRUPT_ENABLE_MASK = 5'h04;
  localparam logic [4:0] RD_BUS_LINE_STATUS = 5'h07;
  localparam logic [4:0] RD_PARALLEL_POLL_MASK = 5'h08;
  localparam logic [4:0] RD_INTERFACE_STATUS_ADDRESS = 5'h0a;
  localparam logic [4:0] RD_INTERRUPT_STATUS_HI = 5'h11;
  localparam logic [4:0] RD_INTERRUPT_STATUS_LO = 5'h13;
  localparam logic [4:0] RD_DATA_LINE_STATUS = 5'h1f;

  localparam logic [4:0] WR_INTERRUPT_ENABLE_MASK = 5'h04;
  localparam logic [4:0] WR_PARALLEL_POLL_MASK = 5'h05;
  localparam logic [4:0] WR_CARD_INTERRUPT_ENABLE = 5'h06;

  // Type code value is arbitrary; every card of this kind returns the same one
  localparam logic [6:0] CARD_TYPE_CODE = 7'h2a;
  localparam logic [7:0] FLOATING_READ = 8'h00;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [4:0] POLL_MASK_RESET = 5'h00;
  localparam logic [15:0] RDATA_RESET = 16'h0000;
  localparam logic [1:0] BUILTIN_LEVEL = 2'h0;

  localparam int IDENT_JUMPER_BIT = 7;
  localparam int POLL_UNCONFIGURE_BIT = 4;
  localparam int POLL_SENSE_BIT = 3;

  typedef struct packed {
    logic atn;
    logic dav;
    logic ndac;
    logic nrfd;
    logic eoi;
    logic srq;
    logic ifc;
    logic ren;
  } bus_control_s;

  typedef struct packed {
    bus_control_s ctrl;
    logic [7:0] data;
    logic jumper_fitted;
    logic [1:0] level_switch;
    logic builtin;
  } pins_s;

  typedef struct packed {
    logic remote;
    logic lockout;
    logic lpas;
    logic tpas;
    logic lads;
    logic tads;
    logic last_addr_lsb;
    logic system_controller;
    logic active_controller;
    logic [4:0] primary_address;
  } if_state_s;

  typedef struct packed {
    logic hi;
    logic lo;
    logic data_line;
  } read_effect_s;

endpackage

// ==== card_regs_props.sv ====
`timescale 1ns/100ps
`default_nettype none
module card_regs_props
  import card_regs_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [4:0] reg_addr,
  input wire logic register_read_statement,
  input wire logic register_write_statement,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire if_state_s if_state,
  input wire logic [15:0] cause_pending,
  input wire logic [15:0] interrupt_enable_mask,
  input wire logic [4:0] parallel_poll_response_mask,
  input wire logic card_interrupt_enable,
  input wire logic irq,
  input wire read_effect_s read_effect
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic rd, wr;
  assign rd = register_read_statement;
  assign wr = register_write_statement;
  property p_mask; wr && reg_addr == 5'h04 |=> interrupt_enable_mask == $past(reg_wdata); endproperty
  a_mask: assert property (p_mask) else $error("mask");
  property p_poll; wr && reg_addr == 5'h05 |=> parallel_poll_response_mask == $past(reg_wdata[4:0]); endproperty
  a_poll: assert property (p_poll) else $error("poll");
  property p_cie; wr && reg_addr == 5'h06 |=> card_interrupt_enable == $past(reg_wdata[0]); endproperty
  a_cie: assert property (p_cie) else $error("cie");
  // Irq lags its causes by exactly one edge
  property p_irq; irq == $past(card_interrupt_enable & |(cause_pending & interrupt_enable_mask)); endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_fx; rd && reg_addr == 5'h11 |=> reg_rvalid && read_effect == 3'b100; endproperty
  a_fx: assert property (p_fx) else $error("effect");
  property p_quiet; !rd |=> !reg_rvalid && read_effect == 3'b000; endproperty
  a_quiet: assert property (p_quiet) else $error("quiet");
  property p_lo; rd && reg_addr == 5'h0a |=> reg_rdata[8:0] == {$past(if_state[7:5]), 1'b0, $past(if_state[4:0])};
  endproperty
  a_lo: assert property (p_lo) else $error("status lo");
  property p_hi; rd && reg_addr == 5'h0a |=> reg_rdata[15:14] == $past(if_state[13:12]) &&
    reg_rdata[12:9] == $past(if_state[11:8]); endproperty
  a_hi: assert property (p_hi) else $error("status hi");
  c_irq: cover property (irq);
  c_lo: cover property (read_effect.lo);
  c_dl: cover property (read_effect.data_line);
endmodule
bind ieee488_card_status_registers card_regs_props u_card_regs_props (.*);
`default_nettype wire

// ==== card_status_registers.sv ====
`timescale 1ns/100ps
`default_nettype none
module ieee488_card_status_registers
  import card_regs_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [4:0] reg_addr,
  input wire logic register_read_statement,
  input wire logic register_write_statement,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire pins_s pins,
  input wire if_state_s if_state,
  input wire logic [15:0] cause_pending,
  input wire logic [7:0] interrupt_status_hi,
  input wire logic [7:0] interrupt_status_lo,
  input wire logic [7:0] data_line_status,
  input wire logic dma0_enabled,
  input wire logic dma1_enabled,
  output logic [15:0] interrupt_enable_mask,
  output logic [4:0] parallel_poll_response_mask,
  output logic card_interrupt_enable,
  output logic irq,
  output read_effect_s read_effect
);

  pins_s sync_a;
  pins_s sync_b;
  logic [15:0] next_mask;
  logic [4:0] next_poll;
  logic next_int_en;
  logic [15:0] next_rdata;
  logic next_rvalid;
  logic next_irq;
  read_effect_s next_effect;
  bus_control_s shown_ctrl;
  logic service_request;

  function automatic logic [7:0] identity_byte(input logic builtin, input logic jumper);
    logic [7:0] v;
    v = {jumper, CARD_TYPE_CODE};
    if (builtin) begin
      v = FLOATING_READ;
    end
    return v;
  endfunction

  // One decode serves every write target
  function automatic logic write_hit(input logic strobe, input logic [4:0] addr, input logic [4:0] code);
    return strobe && (addr == code);
  endfunction

  function automatic logic [7:0] dma_status_byte(input logic builtin, input logic int_en, input logic req,
      input logic [1:0] level, input logic dma1, input logic dma0);
    logic [7:0] v;
    // enabled, requesting, level, unused zero, DMA
    v = {int_en, req, level, 2'h0, dma1, dma0};
    if (builtin) begin
      v = {7'h00, dma0};
      v[5:4] = BUILTIN_LEVEL;
    end
    return v;
  endfunction

  function automatic logic [15:0] status_word(input if_state_s s, input logic atn);
    logic [15:0] v;
    v = 16'h0000;
    v[15:9] = {s.remote, s.lockout, atn, s.lpas, s.tpas, s.lads, s.tads};
    v[8] = s.last_addr_lsb;
    v[7:0] = {s.system_controller, s.active_controller, 1'b0, s.primary_address};
    return v;
  endfunction

  function automatic read_effect_s read_side_effect(input logic strobe, input logic [4:0] addr);
    read_effect_s e;
    e = '0;
    if (strobe) begin
      if (addr == RD_INTERRUPT_STATUS_HI) begin
        e.hi = 1'b1;
      end else if (addr == RD_INTERRUPT_STATUS_LO) begin
        e.lo = 1'b1;
      end else if (addr == RD_DATA_LINE_STATUS) begin
        e.data_line = 1'b1;
      end
    end
    return e;
  endfunction

  // Pins cross into the clock domain before any logic looks at them
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= pins;
      sync_b <= sync_a;
    end
  end

  assign service_request = |(cause_pending & interrupt_enable_mask);

  always_comb begin
    shown_ctrl = sync_b.ctrl;
    if (!if_state.tads) begin
      shown_ctrl.ndac = 1'b0;
      shown_ctrl.nrfd = 1'b0;
    end
    if (!if_state.active_controller) begin
      shown_ctrl.srq = 1'b0;
    end
  end

  always_comb begin
    next_mask = interrupt_enable_mask;
    if (write_hit(register_write_statement, reg_addr, WR_INTERRUPT_ENABLE_MASK)) begin
      next_mask = reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      interrupt_enable_mask <= MASK_RESET;
    end else begin
      interrupt_enable_mask <= next_mask;
    end
  end

  always_comb begin
    next_poll = parallel_poll_response_mask;
    if (write_hit(register_write_statement, reg_addr, WR_PARALLEL_POLL_MASK)) begin
      next_poll = reg_wdata[4:0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      parallel_poll_response_mask <= POLL_MASK_RESET;
    end else begin
      parallel_poll_response_mask <= next_poll;
    end
  end

  always_comb begin
    next_int_en = card_interrupt_enable;
    if (write_hit(register_write_statement, reg_addr, WR_CARD_INTERRUPT_ENABLE)) begin
      next_int_en = reg_wdata[0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      card_interrupt_enable <= 1'b0;
    end else begin
      card_interrupt_enable <= next_int_en;
    end
  end

  // enabled masked cause
  // Registered so the request pin never glitches while causes settle
  always_comb begin
    next_irq = card_interrupt_enable && service_request;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // Valid follows the strobe by one edge, in step with the data
  always_comb begin
    next_rvalid = register_read_statement;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= next_rvalid;
    end
  end

  // Read data holds until the next read, so slow software may fetch it late
  always_comb begin
    next_rdata = reg_rdata;
    if (register_read_statement) begin
      // Unmapped numbers read zero
      next_rdata = 16'h0000;
      if (reg_addr == RD_CARD_IDENTITY) begin
        next_rdata = {8'h00, identity_byte(sync_b.builtin, sync_b.jumper_fitted)};
      end else if (reg_addr == RD_INTERRUPT_DMA_STATUS) begin
        next_rdata = {8'h00, dma_status_byte(sync_b.builtin, card_interrupt_enable, irq, sync_b.level_switch,
            dma1_enabled, dma0_enabled)};
      end else if (reg_addr == RD_INTERRUPT_ENABLE_MASK) begin
        next_rdata = interrupt_enable_mask;
      end else if (reg_addr == RD_BUS_LINE_STATUS) begin
        next_rdata = {shown_ctrl, sync_b.data};
      end else if (reg_addr == RD_PARALLEL_POLL_MASK) begin
        next_rdata = {11'h000, parallel_poll_response_mask};
      end else if (reg_addr == RD_INTERFACE_STATUS_ADDRESS) begin
        next_rdata = status_word(if_state, sync_b.ctrl.atn);
      end else if (reg_addr == RD_INTERRUPT_STATUS_HI) begin
        next_rdata = {8'h00, interrupt_status_hi};
      end else if (reg_addr == RD_INTERRUPT_STATUS_LO) begin
        next_rdata = {8'h00, interrupt_status_lo};
      end else if (reg_addr == RD_DATA_LINE_STATUS) begin
        next_rdata = {8'h00, data_line_status};
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= RDATA_RESET;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // one pulse per disturbing read
  // The engine clears its own flags on this pulse; nothing here is cleared
  always_comb begin
    next_effect = read_side_effect(register_read_statement, reg_addr);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      read_effect <= '0;
    end else begin
      read_effect <= next_effect;
    end
  end

endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import card_regs_pkg::*;
;
  logic clk = 1'b0, resetn = 1'b0, register_read_statement = 1'b0, register_write_statement = 1'b0;
  logic dma0_enabled = 1'b0, dma1_enabled = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000, cause_pending = 16'h0000;
  logic [7:0] interrupt_status_hi = 8'h00, interrupt_status_lo = 8'h00, data_line_status = 8'h00;
  pins_s pins = '0;
  if_state_s if_state = '0;
  logic [15:0] reg_rdata, interrupt_enable_mask, m_mask;
  logic [4:0] parallel_poll_response_mask, m_poll;
  logic reg_rvalid, card_interrupt_enable, irq, m_cie;
  read_effect_s read_effect;
  int errors = 0, tests_run = 0, cyc = 0;
  // Expected read words, in the order the reads are issued
  logic [15:0] exp_q[$];
  logic [4:0] alist [10] = '{5'h01, 5'h03, 5'h04, 5'h07, 5'h08, 5'h0a, 5'h11, 5'h13, 5'h1f, 5'h02};
  ieee488_card_status_registers u_ieee488_card_status_registers (.*);
  // Model of every read; unused bits 3:2 are taken as 0, as the design chose
  function automatic logic [15:0] exp_rd(input logic [4:0] a);
    bus_control_s c;
    logic b;
    c = pins.ctrl;
    b = pins.builtin;
    case (a)
      5'h01: return b ? 16'h0000 : {8'h00, pins.jumper_fitted, CARD_TYPE_CODE};
      5'h03: return b ? {15'h0000, dma0_enabled} : {8'h00, m_cie, m_cie & |(cause_pending & m_mask),
        pins.level_switch, 2'b00, dma1_enabled, dma0_enabled};
      5'h04: return m_mask;
      5'h07: return {c.atn, c.dav, c.ndac & if_state.tads, c.nrfd & if_state.tads, c.eoi,
        c.srq & if_state.active_controller, c.ifc, c.ren, pins.data};
      5'h08: return {11'h000, m_poll};
      5'h0a: return {if_state[13:12], c.atn, if_state[11:5], 1'b0, if_state[4:0]};
      5'h11: return {8'h00, interrupt_status_hi};
      5'h13: return {8'h00, interrupt_status_lo};
      5'h1f: return {8'h00, data_line_status};
      default: return 16'h0000;
    endcase
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    register_write_statement <= 1'b1;
    @(posedge clk);
    register_write_statement <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    reg_addr <= a;
    register_read_statement <= 1'b1;
    exp_q.push_back(exp_rd(a));
    @(posedge clk);
    register_read_statement <= 1'b0;
    #1;
    check({15'h0000, reg_rvalid}, 16'h0001);
    check(reg_rdata, exp_q.pop_front());
    check({13'h0000, read_effect}, {13'h0000, a == 5'h11, a == 5'h13, a == 5'h1f});
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    forever #4 clk = ~clk;
  end
  // Twelve rounds take well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(32'h84aed181));
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      pins <= {17'($urandom), i[1:0], i[2]};
      if_state <= 14'($urandom);
      cause_pending <= 16'($urandom);
      {interrupt_status_hi, interrupt_status_lo, data_line_status, dma0_enabled, dma1_enabled} <= 26'($urandom);
      m_mask = 16'($urandom);
      m_poll = 5'($urandom);
      m_cie = (i % 3 != 0);
      repeat (3) @(posedge clk);
      wr(WR_INTERRUPT_ENABLE_MASK, m_mask);
      wr(WR_PARALLEL_POLL_MASK, {11'($urandom), m_poll});
      wr(WR_CARD_INTERRUPT_ENABLE, {15'($urandom), m_cie});
      wr(5'h1e, 16'($urandom));
      repeat (2) @(posedge clk);
      check(interrupt_enable_mask, m_mask);
      check({11'h000, parallel_poll_response_mask}, {11'h000, m_poll});
      check({15'h0000, irq}, {15'h0000, m_cie & |(cause_pending & m_mask)});
      foreach (alist[k]) rd(alist[k]);
      $display("round %0d done", i);
    end
    // Mid-run reset: registers must return to their reset values
    @(posedge clk);
    resetn <= 1'b0;
    @(posedge clk);
    #1;
    check(interrupt_enable_mask, MASK_RESET);
    check({11'h000, parallel_poll_response_mask}, {11'h000, POLL_MASK_RESET});
    check({15'h0000, irq}, 16'h0000);
    @(posedge clk);
    resetn <= 1'b1;
    m_mask = MASK_RESET;
    m_poll = POLL_MASK_RESET;
    m_cie = 1'b0;
    rd(RD_INTERRUPT_ENABLE_MASK);
    rd(RD_PARALLEL_POLL_MASK);
    rd(RD_INTERRUPT_DMA_STATUS);
    $display("reset round done");
    print_verdict();
  end
endmodule
`default_nettype wire
